// *** verilog/adc_ctrl_regs.svh ***
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
// Contract
// [RULE1] Start falling edge holds both, starts both
// [RULE2] Busy high from start until both done
// [RULE3] Busy falling edge returns stages to track
// [RULE4] Conversion stepped by internal oscillator only
// [RULE5] Two serial outputs, one per converter
// [RULE6] Host reads after finish; data shift on clock
// [RULE7] Reference select high internal, low external
// [RULE8] Reference select never left floating
// [RULE9] Span pins decode; both high never driven
// [RULE10] Span pins stable during acquisition
// [RULE11] Channel pin latched at busy rising edge
// [RULE12] Channel level zero first, one second
// [RULE13] Channel selection resets to first inputs
// [RULE14] Results are twos complement, integer LSB steps
// [RULE15] Twelve or fourteen result bits per converter
// [RULE16] LSB is span over code count
// [RULE17] Start low at end powers down; rise wakes
// [RULE18] No new start while busy high

// ------------------------------------------------
// Register offsets
// ------------------------------------------------
`define ADC_OFS_CTRL      8'h00
`define ADC_OFS_STATUS    8'h04
`define ADC_OFS_IRQ_STAT  8'h08
`define ADC_OFS_IRQ_MASK  8'h0C
`define ADC_OFS_RESULT_A  8'h10
`define ADC_OFS_RESULT_B  8'h14

// ------------------------------------------------
// Fields and reset values
// ------------------------------------------------
`define ADC_CTRL_EN_BIT   0
`define ADC_CTRL_RST      1'h1
`define ADC_IRQ_DONE_BIT  0
`define ADC_IRQ_IGN_BIT   1
`define ADC_IRQ_SPAN_BIT  2
`define ADC_IRQ_W         3
`define ADC_IRQ_MASK_RST  3'h0
`define ADC_CHAN_RST      1'h0

// ------------------------------------------------
// Timing and scaling
// ------------------------------------------------
`define ADC_OSC_DIV       4
`define ADC_RES_BITS      14
`define ADC_UNI_OFFSET    18'sh04000
`endif

// *** verilog/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;
	typedef enum logic [1:0] {
		SPAN_BI10 = 2'b00,
		SPAN_BI5  = 2'b01,
		SPAN_UNI  = 2'b10,
		SPAN_BAD  = 2'b11
	} span_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CONV  = 2'b01,
		ST_PDOWN = 2'b10
	} state_t;

	typedef struct packed {
		logic  start_n;
		logic  sclk;
		logic  chan;
		logic  reference_source_select;
		span_t span;
	} pins_t;
endpackage

// *** verilog/adc_ctrl.sv ***
`timescale 1ns/10ps
`include "adc_ctrl_regs.svh"
module adc_ctrl #(
	parameter int RES_BITS = `ADC_RES_BITS,
	parameter int OSC_DIV  = `ADC_OSC_DIV
) (
	input  wire logic        I_CLK,
	input  wire logic        I_ARST_N,
	input  wire logic        I_CONVERSION_START_N,
	input  wire logic        I_SCLK,
	input  wire logic        I_CHAN_SEL,
	input  wire logic        I_REFERENCE_SOURCE_SELECT,
	input  wire logic        I_INPUT_SPAN_SEL_LO,
	input  wire logic        I_INPUT_SPAN_SEL_HI,
	input  wire logic [15:0] I_CONV_A_INPUT_FIRST,
	input  wire logic [15:0] I_CONV_A_INPUT_SECOND,
	input  wire logic [15:0] I_CONV_B_INPUT_FIRST,
	input  wire logic [15:0] I_CONV_B_INPUT_SECOND,
	input  wire logic [7:0]  I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [31:0] O_RDATA,
	output logic             O_BUSY,
	output logic             O_HOLD,
	output logic             O_DOUT_A,
	output logic             O_DOUT_B,
	output logic             O_INT_REF_EN,
	output logic             O_POWER_DOWN,
	output logic             O_IRQ
);
	localparam int IW = $clog2(RES_BITS);
	localparam int DW = $clog2(OSC_DIV + 1);

	// ------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------
	// [RULE15] Only two result widths
	if (RES_BITS != 12 && RES_BITS != 14) begin : g_bad_res
		$error("RES_BITS must be 12 or 14");
	end
	if (OSC_DIV < 2) begin : g_bad_div
		$error("OSC_DIV must be at least 2");
	end

	// ------------------------------------------------
	// Functions
	// ------------------------------------------------
	// [RULE16] Span sets LSB size
	// Input word: signed, 20 V span over 65536 steps
	function automatic logic [RES_BITS-1:0] scale(input logic [15:0] s,
		input adc_ctrl_pkg::span_t sp);
		logic signed [17:0] v;
		logic        [15:0] c;
		v = {{2{s[15]}}, s};
		case (sp)
			adc_ctrl_pkg::SPAN_BI5: v = v <<< 1;
			adc_ctrl_pkg::SPAN_UNI: v = (v - `ADC_UNI_OFFSET) <<< 1;
			default: v = v;
		endcase
		if (v > 18'sh07FFF) begin
			c = 16'h7FFF;
		end else if (v < -18'sh08000) begin
			c = 16'h8000;
		end else begin
			c = v[15:0];
		end
		// Offset binary target for the SAR
		scale = {~c[15], c[14 -: RES_BITS-1]};
	endfunction

	function automatic logic [RES_BITS-1:0] sar_step(input logic [RES_BITS-1:0] acc,
		input logic [RES_BITS-1:0] tgt, input logic [IW-1:0] bi);
		logic [RES_BITS-1:0] t;
		t = acc | (RES_BITS'(1) << bi);
		sar_step = (t <= tgt) ? t : acc;
	endfunction

	// [RULE14] Offset binary to twos complement
	function automatic logic [RES_BITS-1:0] twos(input logic [RES_BITS-1:0] ob);
		twos = {~ob[RES_BITS-1], ob[RES_BITS-2:0]};
	endfunction

	// ------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------
	adc_ctrl_pkg::pins_t ps1_r, ps2_r, pp_r, pins_in;
	assign pins_in = '{start_n: I_CONVERSION_START_N, sclk: I_SCLK, chan: I_CHAN_SEL,
		reference_source_select: I_REFERENCE_SOURCE_SELECT,
		span: adc_ctrl_pkg::span_t'({I_INPUT_SPAN_SEL_HI, I_INPUT_SPAN_SEL_LO})};

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ps1_r <= '{start_n: 1'b1, sclk: 1'b0, chan: 1'b0, reference_source_select: 1'b0,
				span: adc_ctrl_pkg::SPAN_BI10};
			ps2_r <= '{start_n: 1'b1, sclk: 1'b0, chan: 1'b0, reference_source_select: 1'b0,
				span: adc_ctrl_pkg::SPAN_BI10};
			pp_r  <= '{start_n: 1'b1, sclk: 1'b0, chan: 1'b0, reference_source_select: 1'b0,
				span: adc_ctrl_pkg::SPAN_BI10};
		end else begin
			ps1_r <= pins_in;
			ps2_r <= ps1_r;
			pp_r  <= ps2_r;
		end
	end

	wire start_fall = pp_r.start_n & ~ps2_r.start_n;
	wire start_rise = ~pp_r.start_n & ps2_r.start_n;
	wire sclk_fall  = pp_r.sclk & ~ps2_r.sclk;

	// ------------------------------------------------
	// Internal conversion oscillator
	// ------------------------------------------------
	logic [DW-1:0] osc_cnt_r;
	// [RULE4] Step rate from own divider
	wire osc_tick = (osc_cnt_r == DW'(OSC_DIV - 1));

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			osc_cnt_r <= '0;
		end else begin
			osc_cnt_r <= osc_tick ? '0 : osc_cnt_r + DW'(1);
		end
	end

	// ------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------
	adc_ctrl_pkg::state_t st_r;
	logic                 ctrl_en_r, chan_r, busy_r, hold_r, pd_r;
	logic [IW-1:0]        bi_r;
	logic [RES_BITS-1:0]  tgt_a_r, tgt_b_r, sar_a_r, sar_b_r, res_a_r, res_b_r;

	// [RULE12] Channel level picks input pair
	wire [15:0] smp_a = chan_r ? I_CONV_A_INPUT_SECOND : I_CONV_A_INPUT_FIRST;
	wire [15:0] smp_b = chan_r ? I_CONV_B_INPUT_SECOND : I_CONV_B_INPUT_FIRST;
	wire        idle  = (st_r == adc_ctrl_pkg::ST_IDLE);
	wire        go    = idle & start_fall & ctrl_en_r;
	wire        conv  = (st_r == adc_ctrl_pkg::ST_CONV);
	wire        step  = conv & osc_tick;
	wire        done  = step & (bi_r == '0);
	wire [RES_BITS-1:0] sar_a_nxt = sar_step(sar_a_r, tgt_a_r, bi_r);
	wire [RES_BITS-1:0] sar_b_nxt = sar_step(sar_b_r, tgt_b_r, bi_r);

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			st_r    <= adc_ctrl_pkg::ST_IDLE;
			busy_r  <= 1'b0;
			hold_r  <= 1'b0;
			pd_r    <= 1'b0;
			// [RULE13] First inputs after reset
			chan_r  <= `ADC_CHAN_RST;
			bi_r    <= '0;
			tgt_a_r <= '0;
			tgt_b_r <= '0;
			sar_a_r <= '0;
			sar_b_r <= '0;
			res_a_r <= '0;
			res_b_r <= '0;
		end else begin
			unique case (st_r)
				adc_ctrl_pkg::ST_IDLE: begin
					if (go) begin
						// [RULE1] Both held, both started
						st_r    <= adc_ctrl_pkg::ST_CONV;
						hold_r  <= 1'b1;
						// [RULE2] Busy rises with start
						busy_r  <= 1'b1;
						// [RULE11] Latched pin serves next conversion
						chan_r  <= ps2_r.chan;
						tgt_a_r <= scale(smp_a, ps2_r.span);
						tgt_b_r <= scale(smp_b, ps2_r.span);
						sar_a_r <= '0;
						sar_b_r <= '0;
						bi_r    <= IW'(RES_BITS - 1);
					end
				end
				adc_ctrl_pkg::ST_CONV: begin
					if (step) begin
						sar_a_r <= sar_a_nxt;
						sar_b_r <= sar_b_nxt;
						bi_r    <= bi_r - IW'(1);
					end
					if (done) begin
						// [RULE2] Busy falls when both finish
						busy_r  <= 1'b0;
						// [RULE3] Back to track at busy fall
						hold_r  <= 1'b0;
						res_a_r <= twos(sar_a_nxt);
						res_b_r <= twos(sar_b_nxt);
						// [RULE17] Start still low powers down
						st_r    <= ps2_r.start_n ? adc_ctrl_pkg::ST_IDLE
							: adc_ctrl_pkg::ST_PDOWN;
						// Own flop so the pin never glitches on decode
						pd_r    <= ~ps2_r.start_n;
					end
				end
				adc_ctrl_pkg::ST_PDOWN: begin
					// [RULE17] Rising start wakes the part
					if (start_rise) begin
						st_r <= adc_ctrl_pkg::ST_IDLE;
						pd_r <= 1'b0;
					end
				end
				default: begin
					st_r <= adc_ctrl_pkg::ST_IDLE;
					pd_r <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------
	// Serial result outputs
	// ------------------------------------------------
	logic [RES_BITS-1:0] sh_a_r, sh_b_r;
	logic                dout_a_r, dout_b_r, ref_r;

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sh_a_r   <= '0;
			sh_b_r   <= '0;
			dout_a_r <= 1'b0;
			dout_b_r <= 1'b0;
			ref_r    <= 1'b0;
		end else begin
			// [RULE7] Reference source follows select pin
			ref_r <= ps2_r.reference_source_select;
			if (done) begin
				// [RULE5] One pin per converter, MSB first
				dout_a_r <= ~sar_a_nxt[RES_BITS-1];
				dout_b_r <= ~sar_b_nxt[RES_BITS-1];
				sh_a_r   <= {sar_a_nxt[RES_BITS-2:0], 1'b0};
				sh_b_r   <= {sar_b_nxt[RES_BITS-2:0], 1'b0};
			// [RULE6] Shift only once conversion is over
			end else if (sclk_fall && !busy_r) begin
				dout_a_r <= sh_a_r[RES_BITS-1];
				dout_b_r <= sh_b_r[RES_BITS-1];
				sh_a_r   <= {sh_a_r[RES_BITS-2:0], 1'b0};
				sh_b_r   <= {sh_b_r[RES_BITS-2:0], 1'b0};
			end
		end
	end

	// ------------------------------------------------
	// Register file and interrupts
	// ------------------------------------------------
	logic [`ADC_IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_stat_nxt, ev, clr;
	logic [31:0]           rdata_r, rd_mux;
	logic                  irq_r;

	// [RULE18] Start during busy is ignored, flagged
	// [RULE9] Both span pins high is flagged
	assign ev = {start_fall & idle & (ps2_r.span == adc_ctrl_pkg::SPAN_BAD),
		start_fall & conv, done};
	wire wr_ctrl = I_WR & (I_ADDR == `ADC_OFS_CTRL);
	wire wr_stat = I_WR & (I_ADDR == `ADC_OFS_IRQ_STAT);
	wire wr_mask = I_WR & (I_ADDR == `ADC_OFS_IRQ_MASK);
	assign clr          = wr_stat ? I_WDATA[`ADC_IRQ_W-1:0] : '0;
	// Set wins over a same-cycle clear
	assign irq_stat_nxt = (irq_stat_r & ~clr) | ev;

	always_comb begin
		unique case (I_ADDR)
			`ADC_OFS_CTRL:     rd_mux = {31'h0, ctrl_en_r};
			`ADC_OFS_STATUS:   rd_mux = {24'h0, ps2_r.span, ref_r, chan_r,
				pd_r, hold_r, busy_r, ctrl_en_r};
			`ADC_OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
			`ADC_OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
			`ADC_OFS_RESULT_A: rd_mux = {{(32-RES_BITS){res_a_r[RES_BITS-1]}}, res_a_r};
			`ADC_OFS_RESULT_B: rd_mux = {{(32-RES_BITS){res_b_r[RES_BITS-1]}}, res_b_r};
			default:           rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ctrl_en_r  <= `ADC_CTRL_RST;
			irq_stat_r <= '0;
			irq_mask_r <= `ADC_IRQ_MASK_RST;
			rdata_r    <= 32'h0;
			irq_r      <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_en_r <= I_WDATA[`ADC_CTRL_EN_BIT];
			end
			if (wr_mask) begin
				irq_mask_r <= I_WDATA[`ADC_IRQ_W-1:0];
			end
			irq_stat_r <= irq_stat_nxt;
			rdata_r    <= I_RD ? rd_mux : 32'h0;
			irq_r      <= |(irq_stat_nxt & (wr_mask ? I_WDATA[`ADC_IRQ_W-1:0] : irq_mask_r));
		end
	end

	assign O_RDATA      = rdata_r;
	assign O_BUSY       = busy_r;
	assign O_HOLD       = hold_r;
	assign O_DOUT_A     = dout_a_r;
	assign O_DOUT_B     = dout_b_r;
	assign O_INT_REF_EN = ref_r;
	assign O_POWER_DOWN = pd_r;
	assign O_IRQ        = irq_r;
endmodule

// *** verif/adc_ctrl_sva.sv ***
`timescale 1ns/10ps
module adc_ctrl_sva #(
	parameter int RES_BITS = 14,
	parameter int OSC_DIV  = 4
) (
	input wire logic        I_CLK,
	input wire logic        I_ARST_N,
	input wire logic        I_CONVERSION_START_N,
	input wire logic        I_SCLK,
	input wire logic [7:0]  I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic        I_WR,
	input wire logic        O_BUSY,
	input wire logic        O_HOLD,
	input wire logic        O_DOUT_A,
	input wire logic        O_DOUT_B,
	input wire logic        O_POWER_DOWN,
	input wire logic        O_IRQ
);
	// First step lands one to OSC_DIV cycles after busy rises
	localparam int BMIN = (RES_BITS - 1) * OSC_DIV + 1;
	localparam int BMAX = RES_BITS * OSC_DIV;
	logic [7:0] bcnt_r, bcnt_nxt, quiet_r, quiet_nxt;
	logic [2:0] mask_r;
	logic       sclk_r, mask_we, en_r, en_we;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	// ------------
	// Helpers
	// ------------
	// Quiet count saturates so a long idle never wraps
	assign mask_we   = I_WR && I_ADDR == 8'h0C;
	assign en_we     = I_WR && I_ADDR == 8'h00;
	assign bcnt_nxt  = O_BUSY ? bcnt_r + 8'h01 : 8'h00;
	assign quiet_nxt = (I_SCLK != sclk_r) ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hFF};
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			{bcnt_r, quiet_r, sclk_r} <= '0;
		end else begin
			{bcnt_r, quiet_r, sclk_r} <= {bcnt_nxt, quiet_nxt, I_SCLK};
		end
	end
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			mask_r <= 3'h0;
		end else if (mask_we) begin
			mask_r <= I_WDATA[2:0];
		end
	end
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			en_r <= 1'b1;
		end else if (en_we) begin
			en_r <= I_WDATA[0];
		end
	end
	property p_hold_busy; O_HOLD == O_BUSY; endproperty
	a_hold_busy: assert property (p_hold_busy) else $error("hold vs busy");
	property p_busy_len; $fell(O_BUSY) |-> bcnt_r >= BMIN && bcnt_r <= BMAX; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy width");
	property p_start; $fell(I_CONVERSION_START_N) && !O_BUSY && !O_POWER_DOWN && en_r
		|-> ##[2:6] $rose(O_BUSY); endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_pd_enter; $fell(O_BUSY) && !I_CONVERSION_START_N
		&& !$past(I_CONVERSION_START_N, 4) |-> ##[0:2] O_POWER_DOWN; endproperty
	a_pd_enter: assert property (p_pd_enter) else $error("no power down");
	property p_pd_wake; O_POWER_DOWN && $rose(I_CONVERSION_START_N) |-> ##[2:6] !O_POWER_DOWN;
	endproperty
	a_pd_wake: assert property (p_pd_wake) else $error("no wake");
	property p_pd_idle; O_POWER_DOWN |-> !O_BUSY; endproperty
	a_pd_idle: assert property (p_pd_idle) else $error("busy in power down");
	property p_irq_done; $fell(O_BUSY) && mask_r[0] |-> ##[0:2] O_IRQ; endproperty
	a_irq_done: assert property (p_irq_done) else $error("no irq");
	property p_dout_quiet; quiet_r > 8'h08 && I_CONVERSION_START_N && !O_BUSY && !$past(O_BUSY)
		|-> $stable(O_DOUT_A) && $stable(O_DOUT_B); endproperty
	a_dout_quiet: assert property (p_dout_quiet) else $error("data moved");
	c_conv: cover property ($rose(O_BUSY));
	c_pd: cover property ($rose(O_POWER_DOWN));
	c_irq: cover property ($rose(O_IRQ));
endmodule
bind adc_ctrl adc_ctrl_sva #(.RES_BITS(RES_BITS), .OSC_DIV(OSC_DIV)) chk (
	.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_CONVERSION_START_N(I_CONVERSION_START_N),
	.I_SCLK(I_SCLK), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .O_BUSY(O_BUSY),
	.O_HOLD(O_HOLD), .O_DOUT_A(O_DOUT_A), .O_DOUT_B(O_DOUT_B),
	.O_POWER_DOWN(O_POWER_DOWN), .O_IRQ(O_IRQ)
);

// *** verif/adc_host_model.sv ***
`timescale 1ns/10ps
module adc_host_model #(
	parameter int NBITS = 14
) (
	input  wire logic i_clk,
	input  wire logic i_dout_a,
	input  wire logic i_dout_b,
	output logic      o_sclk
);
	// ------------
	// Serial read
	// ------------
	// Clock parked low between frames
	initial o_sclk = 1'b0;
	// Read only after end of conversion
	task automatic frame(input int gap, output logic [15:0] a, output logic [15:0] b);
		a = 16'h0000;
		b = 16'h0000;
		repeat (gap) @(posedge i_clk);
		// Ten block clocks per bit: 80 ns link period
		for (int i = 0; i < NBITS; i++) begin
			repeat (5) @(posedge i_clk);
			o_sclk <= 1'b1;
			a = {a[14:0], i_dout_a};
			b = {b[14:0], i_dout_b};
			repeat (5) @(posedge i_clk);
			o_sclk <= 1'b0;
		end
	endtask
endmodule

// *** verif/adc_ctrl_test.sv ***
`timescale 1ns/10ps
module adc_ctrl_test;
	logic        clk, arst_n, start_n, chan, reference_source_select, span_lo, span_hi, wr, rd;
	logic        sclk, busy, hold, dout_a, dout_b, intref, pdown, irq;
	logic [15:0] a1, a2, b1, b2;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, v;
	int          miscompares, checks, cyc;
	adc_ctrl DUT (
		.I_CLK(clk), .I_ARST_N(arst_n), .I_CONVERSION_START_N(start_n), .I_SCLK(sclk),
		.I_CHAN_SEL(chan), .I_REFERENCE_SOURCE_SELECT(reference_source_select), .I_INPUT_SPAN_SEL_LO(span_lo),
		.I_INPUT_SPAN_SEL_HI(span_hi), .I_CONV_A_INPUT_FIRST(a1), .I_CONV_A_INPUT_SECOND(a2),
		.I_CONV_B_INPUT_FIRST(b1), .I_CONV_B_INPUT_SECOND(b2), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_BUSY(busy), .O_HOLD(hold), .O_DOUT_A(dout_a),
		.O_DOUT_B(dout_b), .O_INT_REF_EN(intref), .O_POWER_DOWN(pdown), .O_IRQ(irq)
	);
	adc_host_model #(.NBITS(14)) HOST (
		.i_clk(clk), .i_dout_a(dout_a), .i_dout_b(dout_b), .o_sclk(sclk)
	);
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			results();
		end
	end
	// ------------
	// Tasks
	// ------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask
	task automatic wt(input logic lvl);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (busy !== lvl && n < 100);
		chk("busy", 32'(lvl), 32'(busy));
	endtask
	task automatic conv(input logic ch, input logic [1:0] sp, input logic rf,
			input logic [13:0] ea, input logic [13:0] eb, input logic mk, input logic pd);
		logic [15:0] a;
		logic [15:0] b;
		wrr(8'h0C, {31'h0, mk});
		chan <= ch;
		{span_hi, span_lo} <= sp;
		reference_source_select <= rf;
		repeat (8) @(posedge clk);
		start_n <= 1'b0;
		wt(1'b1);
		chk("hold", 32'h1, 32'(hold));
		@(posedge clk);
		start_n <= !pd;
		wt(1'b0);
		chk("hold", 32'h0, 32'(hold));
		repeat (4) @(negedge clk);
		chk("power_down", 32'(pd), 32'(pdown));
		HOST.frame(pd ? 38 : 0, a, b);
		chk("dout_a", 32'(ea), 32'(a[13:0]));
		chk("dout_b", 32'(eb), 32'(b[13:0]));
		rdr(8'h10);
		chk("result_a", {{18{ea[13]}}, ea}, v);
		rdr(8'h14);
		chk("result_b", {{18{eb[13]}}, eb}, v);
		rdr(8'h08);
		chk("irq_status", 32'h1, v);
		chk("irq", 32'(mk), 32'(irq));
		chk("int_ref", 32'(rf), 32'(intref));
		wrr(8'h08, 32'h7);
		start_n <= 1'b1;
		repeat (8) @(negedge clk);
		chk("irq", 32'h0, 32'(irq));
		chk("power_down", 32'h0, 32'(pdown));
	endtask
	task automatic idle_off();
		wrr(8'h00, 32'h0);
		start_n <= 1'b0;
		repeat (8) @(negedge clk);
		chk("busy_off", 32'h0, 32'(busy));
		rdr(8'h04);
		chk("status_off", 32'h40, v);
		wrr(8'h00, 32'h1);
		start_n <= 1'b1;
		repeat (8) @(negedge clk);
		chk("busy_on", 32'h0, 32'(busy));
	endtask
	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		{clk, arst_n, chan, span_lo, span_hi, wr, rd} = '0;
		{start_n, reference_source_select} = 2'b11;
		{a1, a2, b1, b2} = {16'h1000, 16'h0C00, 16'hF000, 16'h6000};
		addr = 8'h00;
		wdata = 32'h0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk);
		rdr(8'h04);
		chk("status", 32'h21, v);
		rdr(8'h18);
		chk("unmapped", 32'h0, v);
		conv(1'b1, 2'b00, 1'b1, 14'h0400, 14'h3C00, 1'b0, 1'b0);
		conv(1'b0, 2'b01, 1'b0, 14'h0600, 14'h1FFF, 1'b1, 1'b0);
		idle_off();
		conv(1'b0, 2'b10, 1'b1, 14'h2800, 14'h2000, 1'b1, 1'b1);
		conv(1'b0, 2'b00, 1'b1, 14'h0400, 14'h3C00, 1'b0, 1'b0);
		results();
	end
endmodule
